// >>> rtl/dac_mode_map.vh
// register map, field positions, write masks and reset values of the converter mode control bank
`ifndef DAC_MODE_MAP_VH
`define DAC_MODE_MAP_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define PORT_AND_POWER_CONTROL 4'h0
`define FILTER_AND_MIXING_SETUP 4'h1
`define INPUT_FORMAT_SETUP 4'h2
`define PLL_PRESCALER_SETUP 4'h3
`define PLL_ENABLE_AND_PUMP 4'h4
`define INPHASE_FINE_GAIN 4'h5
`define INPHASE_COARSE_GAIN 4'h6
`define INPHASE_OFFSET_HIGH 4'h7
`define INPHASE_OFFSET_LOW_DIR 4'h8
`define QUAD_FINE_GAIN 4'h9
`define QUAD_COARSE_GAIN 4'ha
`define QUAD_OFFSET_HIGH 4'hb
`define QUAD_OFFSET_LOW_DIR 4'hc
`define SILICON_VERSION 4'hd

// ****************************************************************
// field positions
// ****************************************************************
`define BIDIR_BIT 7
`define LSB_FIRST_BIT 6
`define SOFT_RESET_BIT 5
`define SLEEP_BIT 4
`define POWER_DOWN_BIT 3
`define RES_MODE_BIT 2
`define PLL_LOCK_BIT 1
`define INSTR_READ_BIT 7
`define INSTR_COUNT_HI 6
`define INSTR_COUNT_LO 5

// ****************************************************************
// writable bits per location
// ****************************************************************
`define MASK_00 8'hdc
`define MASK_01 8'hfe
`define MASK_02 8'he8
`define MASK_03 8'h03
`define MASK_04 8'hc7
`define MASK_FINE 8'hff
`define MASK_COARSE 8'h0f
`define MASK_OFS_HIGH 8'hff
`define MASK_OFS_LOW 8'h83

// ****************************************************************
// reset values
// ****************************************************************
`define RESET_VALUE 8'h00

`endif

// >>> rtl/dual_dac_mode_control.v
// serial-port mode control register bank of a dual interpolating converter
// Function
// - location 00 bit 7 selects bidirectional data pin
// - bidirectional pin driven on read instructions
// - location 00 bit 6 selects lsb-first order
// - writing bit 5 restores default register values
// - reset bit reads zero; location 00 kept
// - bit 4 sleeps both output currents
// - bit 3 powers down whole device
// - bit 2 picks one or two resistors
// - bit 1 reads pll lock when enabled
// - location 01 bits 7:6 set interpolation
// - interpolation code 00 means factor one
// - location 01 bits 5:4 set modulation
// - location 01 bit 3 enables zero stuffing
// - location 01 bit 2 real/complex mixing
// - location 01 bit 1 rotation sign
// - location 02 bit 7 unsigned data coding
// - location 02 bit 6 one-port interleaved mode
// - location 02 bit 3 external data clock
// - location 04 bit 7 enables pll
// - location 04 bit 6 programmable charge pump
// - fine gain at 05 and 09
// - coarse gain bits 3:0 at 06, 0A
// - ten-bit offset split high/low locations
// - bit 7 of 08/0C steers offset current
`timescale 1ns/10ps
`include "dac_mode_map.vh"

module dual_dac_mode_control #(
    parameter [3:0] VERSION = 4'h1 // arbitrary version value
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire ce_i,
    input wire sclk_i,
    input wire cs_b_i,
    input wire sdio_i,
    output reg sdio_o,
    output reg sdio_oe_o,
    output reg sdo_o,
    input wire pll_lock_i,
    output wire sleep_o,
    output wire power_down_o,
    output wire reference_resistor_mode_o,
    output wire [1:0] interp_rate_o,
    output wire [1:0] mod_mode_o,
    output wire zero_stuff_o,
    output wire real_mix_o,
    output wire mix_sign_pos_o,
    output wire unsigned_data_o,
    output wire one_port_o,
    output wire data_clock_pin_drive_o,
    output wire ext_data_clock_o,
    output wire [1:0] pll_prescaler_o,
    output wire pll_enable_o,
    output wire pump_program_o,
    output wire [2:0] pump_ctrl_o,
    output wire [7:0] inphase_fine_gain_o,
    output wire [3:0] inphase_coarse_gain_o,
    output wire [9:0] inphase_offset_o,
    output wire inphase_offset_pos_o,
    output wire [7:0] quad_fine_gain_o,
    output wire [3:0] quad_coarse_gain_o,
    output wire [9:0] quad_offset_o,
    output wire quad_offset_pos_o
);

    // ****************************************************************
    // serial engine states
    // ****************************************************************
    localparam [1:0] ST_INSTR = 2'd0;
    localparam [1:0] ST_DATA = 2'd1;
    localparam [1:0] ST_DONE = 2'd2;
    // first location with no storage behind it; reads from here up are decoded apart
    localparam [3:0] LAST_ADDR = `SILICON_VERSION;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    reg sclk_m_reg;
    reg sclk_s_reg;
    reg sclk_d_reg;
    reg cs_m_reg;
    reg cs_s_reg;
    reg sdio_m_reg;
    reg sdio_s_reg;
    reg lock_m_reg;
    reg lock_s_reg;
    wire sclk_rise;
    wire sclk_fall;

    // limitation: each phase of sclk_i must last three clk_i periods, or an edge
    // is missed and the frame slips by a bit; chip select high always recovers it
    // sclk idles low and chip select high after reset, so no false edge follows it
    // every serial pin and pll_lock_i cross two flops before any logic looks at them; rst_b_i and ce_i are used directly
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            sclk_m_reg <= 1'b0;
            sclk_s_reg <= 1'b0;
            sclk_d_reg <= 1'b0;
            cs_m_reg <= 1'b1;
            cs_s_reg <= 1'b1;
            sdio_m_reg <= 1'b0;
            sdio_s_reg <= 1'b0;
            lock_m_reg <= 1'b0;
            lock_s_reg <= 1'b0;
        end else if (ce_i) begin
            sclk_m_reg <= sclk_i;
            sclk_s_reg <= sclk_m_reg;
            sclk_d_reg <= sclk_s_reg;
            cs_m_reg <= cs_b_i;
            cs_s_reg <= cs_m_reg;
            sdio_m_reg <= sdio_i;
            sdio_s_reg <= sdio_m_reg;
            lock_m_reg <= pll_lock_i;
            lock_s_reg <= lock_m_reg;
        end
    end

    // the third flop only serves edge detection; nothing but the second reads the first
    // edges found on the resynchronised serial clock only
    assign sclk_rise = sclk_s_reg & ~sclk_d_reg;
    assign sclk_fall = ~sclk_s_reg & sclk_d_reg;

    // ****************************************************************
    // register storage
    // ****************************************************************
    reg [7:0] cfg_reg [0:12];
    reg [1:0] state_reg;
    reg [2:0] bit_cnt_reg;
    reg [7:0] shift_reg;
    reg [7:0] tx_reg;
    reg read_reg;
    reg [4:0] addr_reg;
    reg [1:0] left_reg;
    reg load_reg;
    reg wr_en;
    reg [7:0] wr_mask;
    reg [7:0] rd_data;
    wire lsb_first;
    wire bidir;
    wire [7:0] shift_next;
    wire [2:0] tx_idx;
    wire byte_end;
    wire soft_reset;
    integer i;

    // bit order is read from the stored location, so a change applies from the next byte
    assign lsb_first = cfg_reg[0][`LSB_FIRST_BIT];
    assign bidir = cfg_reg[0][`BIDIR_BIT];

    // incoming bit lands at either end of the shifter by bit order
    assign shift_next = lsb_first ? {sdio_s_reg, shift_reg[7:1]} : {shift_reg[6:0], sdio_s_reg};
    assign tx_idx = lsb_first ? bit_cnt_reg : 3'd7 - bit_cnt_reg;
    assign byte_end = sclk_rise && (bit_cnt_reg == 3'd7);
    // soft reset is decoded from the incoming byte, so it acts on the edge of the write
    assign soft_reset = wr_en && (addr_reg == {1'b0, `PORT_AND_POWER_CONTROL}) && shift_next[`SOFT_RESET_BIT];

    // writable bits of the addressed location; unmapped and read-only give zero
    // bits outside a mask read zero, except the lock bit of 00 and the version at 0d, so writing all ones maps the bank
    always @* begin
        wr_mask = 8'h00;
        case (addr_reg[3:0])
            `PORT_AND_POWER_CONTROL: wr_mask = `MASK_00; // reset bit never stored
            `FILTER_AND_MIXING_SETUP: wr_mask = `MASK_01;
            `INPUT_FORMAT_SETUP: wr_mask = `MASK_02;
            `PLL_PRESCALER_SETUP: wr_mask = `MASK_03;
            `PLL_ENABLE_AND_PUMP: wr_mask = `MASK_04;
            `INPHASE_FINE_GAIN, `QUAD_FINE_GAIN: wr_mask = `MASK_FINE;
            `INPHASE_COARSE_GAIN, `QUAD_COARSE_GAIN: wr_mask = `MASK_COARSE;
            `INPHASE_OFFSET_HIGH, `QUAD_OFFSET_HIGH: wr_mask = `MASK_OFS_HIGH;
            `INPHASE_OFFSET_LOW_DIR, `QUAD_OFFSET_LOW_DIR: wr_mask = `MASK_OFS_LOW;
            default: wr_mask = 8'h00; // version location ignores writes
        endcase
        if (addr_reg[4]) begin
            wr_mask = 8'h00;
        end
    end

    // read mux; lock shown only while the pll runs, reset bit always zero
    // unmapped locations 0e to 1f read as zero, so a host that scans the
    // space sees no ghost copies of real registers
    always @* begin
        rd_data = 8'h00;
        if (!addr_reg[4] && addr_reg[3:0] < LAST_ADDR) begin
            rd_data = cfg_reg[addr_reg[3:0]];
        end
        if (addr_reg == {1'b0, `PORT_AND_POWER_CONTROL}) begin
            rd_data[`SOFT_RESET_BIT] = 1'b0;
            rd_data[`PLL_LOCK_BIT] = lock_s_reg & cfg_reg[4][7];
        end
        if (addr_reg == {1'b0, `SILICON_VERSION}) begin
            rd_data = {4'h0, VERSION};
        end
    end

    // a data byte is written when its eighth bit is taken
    // read frames never write, although the shifter keeps filling
    always @* begin
        wr_en = byte_end && (state_reg == ST_DATA) && !read_reg;
    end

    // ****************************************************************
    // serial engine
    // ****************************************************************
    // instruction byte then one to four data bytes; address steps up each byte.
    // chip select high aborts the frame at once, so a stopped clock leaves no state
    // instruction layout: read flag, byte count minus one, five-bit address
    // a cut data byte never reaches a register, as writes need the eighth rise
    // the engine needs no timer: sclk_i edges alone pace every step
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_reg <= ST_INSTR;
            bit_cnt_reg <= 3'd0;
            shift_reg <= 8'h00;
            tx_reg <= 8'h00;
            read_reg <= 1'b0;
            addr_reg <= 5'd0;
            left_reg <= 2'd0;
            load_reg <= 1'b0;
            sdio_o <= 1'b0;
            sdio_oe_o <= 1'b0;
            sdo_o <= 1'b0;
        end else if (ce_i) begin
            if (cs_s_reg) begin
                state_reg <= ST_INSTR;
                bit_cnt_reg <= 3'd0;
                sdio_oe_o <= 1'b0;
            end else begin
                // bits after the counted bytes are ignored until chip select rises
                if (sclk_rise && state_reg != ST_DONE) begin
                    shift_reg <= shift_next;
                    bit_cnt_reg <= bit_cnt_reg + 3'd1;
                end
                case (state_reg)
                    ST_INSTR: begin
                        if (byte_end) begin
                            read_reg <= shift_next[`INSTR_READ_BIT];
                            left_reg <= shift_next[`INSTR_COUNT_HI:`INSTR_COUNT_LO];
                            addr_reg <= shift_next[4:0];
                            state_reg <= ST_DATA;
                            // pin turns round only in bidirectional mode
                            sdio_oe_o <= shift_next[`INSTR_READ_BIT] & bidir;
                        end
                    end
                    ST_DATA: begin
                        if (byte_end) begin
                            addr_reg <= addr_reg + 5'd1;
                            // bytes still to move; zero means this byte was the last
                            left_reg <= left_reg - 2'd1;
                            if (left_reg == 2'd0) begin
                                state_reg <= ST_DONE;
                                sdio_oe_o <= 1'b0;
                            end
                        end
                    end
                    ST_DONE: begin
                        sdio_oe_o <= 1'b0;
                    end
                    default: begin
                        state_reg <= ST_INSTR;
                    end
                endcase
            end
            // the address moves on the edge that ends a byte, so the outgoing
            // byte is fetched one clock later, well before its first falling edge
            load_reg <= byte_end;
            if (state_reg != ST_DATA || load_reg) begin
                tx_reg <= rd_data;
            end
            // read bits change on the falling edge, held through the rising one
            if (sclk_fall && state_reg == ST_DATA && read_reg && !cs_s_reg) begin
                sdio_o <= tx_reg[tx_idx];
                sdo_o <= tx_reg[tx_idx];
            end
        end
    end

    // ****************************************************************
    // register file
    // ****************************************************************
    // a soft reset clears every location but 00, which still takes the byte
    // soft reset and its write share one edge without conflict, as that write targets 00
    always @(posedge clk_i) begin
        if (!rst_b_i) begin
            for (i = 0; i < 13; i = i + 1) begin
                cfg_reg[i] <= `RESET_VALUE;
            end
        end else if (ce_i) begin
            if (soft_reset) begin
                for (i = 1; i < 13; i = i + 1) begin
                    cfg_reg[i] <= `RESET_VALUE;
                end
            end
            if (wr_en && wr_mask != 8'h00) begin
                cfg_reg[addr_reg[3:0]] <= shift_next & wr_mask;
            end
        end
    end

    // ****************************************************************
    // control outputs
    // ****************************************************************
    // every output comes straight from a storage flop, so none glitches mid-frame
    // location 00: port, power and reference
    assign sleep_o = cfg_reg[0][`SLEEP_BIT];
    assign power_down_o = cfg_reg[0][`POWER_DOWN_BIT];
    assign reference_resistor_mode_o = cfg_reg[0][`RES_MODE_BIT];

    // location 01: code 00 is straight through, no interpolation
    assign interp_rate_o = cfg_reg[1][7:6];
    assign mod_mode_o = cfg_reg[1][5:4];
    assign zero_stuff_o = cfg_reg[1][3];
    assign real_mix_o = cfg_reg[1][2];
    assign mix_sign_pos_o = cfg_reg[1][1];

    // location 02: input interface; bit 5 sets the data clock pin drive strength
    assign unsigned_data_o = cfg_reg[2][7];
    assign one_port_o = cfg_reg[2][6];
    assign data_clock_pin_drive_o = cfg_reg[2][5];
    assign ext_data_clock_o = cfg_reg[2][3];

    // locations 03 and 04: pll
    assign pll_prescaler_o = cfg_reg[3][1:0];
    assign pll_enable_o = cfg_reg[4][7];
    assign pump_program_o = cfg_reg[4][6];
    assign pump_ctrl_o = cfg_reg[4][2:0];

    // per-channel gain and offset
    assign inphase_fine_gain_o = cfg_reg[5];
    assign inphase_coarse_gain_o = cfg_reg[6][3:0];
    assign inphase_offset_o = {cfg_reg[7], cfg_reg[8][1:0]};
    assign inphase_offset_pos_o = cfg_reg[8][7];
    assign quad_fine_gain_o = cfg_reg[9];
    assign quad_coarse_gain_o = cfg_reg[10][3:0];
    assign quad_offset_o = {cfg_reg[11], cfg_reg[12][1:0]};
    assign quad_offset_pos_o = cfg_reg[12][7];

endmodule // dual_dac_mode_control

// >>> dv/dual_dac_mode_control_properties.sv
// concurrent checks on the ports of the mode control bank
`timescale 1ns/10ps
module dual_dac_mode_control_properties (
    input wire clk_i,
    input wire rst_b_i,
    input wire sclk_i,
    input wire cs_b_i,
    input wire sdio_o,
    input wire sdio_oe_o,
    input wire sdo_o,
    input wire [1:0] interp_rate_o,
    input wire [9:0] inphase_offset_o,
    input wire sleep_o,
    input wire [1:0] pll_prescaler_o
);
    // ****************************************
    // port relations
    // ****************************************
    // control fields gathered so one check covers them all
    wire [14:0] ctl = {interp_rate_o, inphase_offset_o, sleep_o, pll_prescaler_o};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_reset_clear: assert property ($rose(rst_b_i) |-> ctl == 15'h0 && !sdio_oe_o)
        else $error("outputs not cleared after reset");
    a_idle_hold: assert property ((cs_b_i && rst_b_i)[*6] |-> $stable(ctl))
        else $error("control field moved outside a frame");
    // commits land a few cycles after a clock rise, inside the frame
    a_ctl_on_rise: assert property (rst_b_i && $past(rst_b_i) && $changed(ctl) |-> $past(sclk_i, 2) && !cs_b_i)
        else $error("control field changed away from a clock rise");
    a_sdo_on_fall: assert property (rst_b_i && $past(rst_b_i) && $changed(sdo_o) |-> !$past(sclk_i, 2))
        else $error("read bit moved away from a falling edge");
    a_oe_match: assert property (sdio_oe_o |-> sdio_o == sdo_o)
        else $error("both data outputs disagree while driving");
    a_oe_rise: assert property ($rose(sdio_oe_o) |-> $past(sclk_i, 2) && !cs_b_i)
        else $error("data pin driven outside a read phase");
    a_oe_hold: assert property ($rose(sdio_oe_o) |-> (sdio_oe_o || cs_b_i)[*8])
        else $error("data pin drive dropped early");
    a_oe_idle: assert property (cs_b_i[*5] |-> !sdio_oe_o)
        else $error("data pin driven while deselected");
    c_read: cover property ($rose(sdio_oe_o));
    c_sleep: cover property ($rose(sleep_o));
    c_rate: cover property (interp_rate_o == 2'b11);
endmodule // dual_dac_mode_control_properties

// >>> dv/spi_host_model.sv
// behavioural serial host that frames instruction and data bytes
`timescale 1ns/10ps
module spi_host_model (
    output reg sclk_o,
    output reg cs_b_o,
    output reg sdio_o,
    input wire sdio_i,
    input wire sdo_i
);
    // idle: clock low and still, chip not selected
    initial begin
        sclk_o = 1'b0;
        cs_b_o = 1'b1;
        sdio_o = 1'b0;
    end
    // data moves with the low phase; read bits are taken just before the rising
    // edge, since the device changes its drive only a few clocks after the falling edge
    task byte_io(input lsb, input drv, input [7:0] tx, output [7:0] ra, output [7:0] rb);
        integer i;
        integer b;
        for (i = 0; i < 8; i = i + 1) begin
            b = lsb ? i : 7 - i;
            sdio_o = drv ? tx[b] : ~sdio_o; // released line has no pull, so it wanders
            #30 ra[b] = sdio_i;
            rb[b] = sdo_i;
            #2 sclk_o = 1'b1;
            #32 sclk_o = 1'b0;
        end
    endtask
    // whole frame: instruction, then n+1 bytes at rising addresses
    task xfer(input lsb, input rd, input [4:0] a, input [1:0] n, input [31:0] wd,
              output [31:0] rs, output [31:0] ro);
        integer k;
        reg [7:0] x;
        reg [7:0] y;
        rs = 32'h0;
        ro = 32'h0;
        cs_b_o = 1'b0;
        byte_io(lsb, 1'b1, {rd, n, a}, x, y);
        for (k = 0; k <= n; k = k + 1) begin
            byte_io(lsb, !rd, wd[8*k+:8], x, y);
            rs[8*k+:8] = x;
            ro[8*k+:8] = y;
        end
        #40 cs_b_o = 1'b1;
        #40;
    endtask
endmodule // spi_host_model

// >>> dv/tb_dual_dac_mode_control.sv
// self-checking bench: a serial host programs the mode control bank
`timescale 1ns/10ps
`include "dac_mode_map.vh"
module tb_dual_dac_mode_control;
    localparam [3:0] VER = 4'h6; // arbitrary version value
    reg clk_i = 1'b0;
    reg rst_b_i = 1'b0;
    reg pll_lock_i = 1'b0;
    reg lsb = 1'b0;
    reg [31:0] rs;
    reg [31:0] ro;
    integer n_fail = 0;
    integer checks = 0;
    integer v;
    wire sclk_i, cs_b_i, host_sdio, sdio_o, sdio_oe_o, sdo_o, sleep_o, power_down_o, reference_resistor_mode_o;
    wire zero_stuff_o, real_mix_o, mix_sign_pos_o, unsigned_data_o, one_port_o, ext_data_clock_o;
    wire pll_enable_o, pump_program_o, inphase_offset_pos_o, quad_offset_pos_o;
    wire [1:0] interp_rate_o, mod_mode_o, pll_prescaler_o;
    wire [2:0] pump_ctrl_o;
    wire [9:0] inphase_offset_o, quad_offset_o;
    wire [7:0] inphase_fine_gain_o, quad_fine_gain_o;
    wire [3:0] inphase_coarse_gain_o, quad_coarse_gain_o;
    wire data_clock_pin_drive_o;
    // level of the shared data pin: whoever enables drives it
    wire sdio_i = sdio_oe_o ? sdio_o : host_sdio;
    always #4 clk_i = ~clk_i;
    dual_dac_mode_control #(.VERSION(VER)) dut_u (.clk_i, .rst_b_i, .ce_i(1'b1), .sclk_i, .cs_b_i, .sdio_i,
        .sdio_o, .sdio_oe_o, .sdo_o, .pll_lock_i, .sleep_o, .power_down_o, .reference_resistor_mode_o,
        .interp_rate_o, .mod_mode_o, .zero_stuff_o, .real_mix_o, .mix_sign_pos_o, .unsigned_data_o, .one_port_o,
        .data_clock_pin_drive_o, .ext_data_clock_o, .pll_prescaler_o, .pll_enable_o, .pump_program_o,
        .pump_ctrl_o, .inphase_fine_gain_o, .inphase_coarse_gain_o, .inphase_offset_o, .inphase_offset_pos_o,
        .quad_fine_gain_o, .quad_coarse_gain_o, .quad_offset_o, .quad_offset_pos_o);
    spi_host_model host_u (.sclk_o(sclk_i), .cs_b_o(cs_b_i), .sdio_o(host_sdio), .sdio_i(sdio_i), .sdo_i(sdo_o));
    // ****************************************
    // access and compare tasks
    // ****************************************
    // frames start on a falling clock edge, so no pin moves on a sampling edge
    task wr(input [4:0] a, input [1:0] n, input [31:0] d);
        @(negedge clk_i);
        host_u.xfer(lsb, 1'b0, a, n, d, rs, ro);
    endtask
    task rd(input [4:0] a, input [1:0] n);
        @(negedge clk_i);
        host_u.xfer(lsb, 1'b1, a, n, 32'h0, rs, ro);
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        checks = checks + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // main sequence; each frame is slow, so reads follow writes directly
    initial begin
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(5'h00, 2'd3);
        chk("r00", 32'h0, ro);
        rd(5'h0c, 2'd3);
        chk("r0c", {20'h0, VER, 8'h00}, ro);
        chk("rate0", 32'h0, interp_rate_o);
        $display("test reset values done");
        wr(5'h01, 2'd3, 32'hffffffff);
        wr(5'h05, 2'd3, 32'hffffffff);
        wr(5'h09, 2'd3, 32'hffffffff);
        wr(5'h0d, 2'd1, 32'hffffffff);
        rd(5'h01, 2'd3);
        chk("r01", {`MASK_04, `MASK_03, `MASK_02, `MASK_01}, ro);
        rd(5'h09, 2'd3);
        chk("r09", {`MASK_OFS_LOW, `MASK_OFS_HIGH, `MASK_COARSE, `MASK_FINE}, ro);
        rd(5'h0d, 2'd1);
        chk("r0d", {28'h0, VER}, ro);
        chk("ich", 32'h7ffff, {inphase_offset_pos_o, inphase_offset_o, inphase_fine_gain_o});
        chk("chan", 32'h7ffffff, {quad_fine_gain_o, quad_coarse_gain_o, quad_offset_o, inphase_coarse_gain_o,
            data_clock_pin_drive_o});
        chk("qdir", 32'h1, quad_offset_pos_o);
        chk("mix", 32'h7f, {interp_rate_o, mod_mode_o, zero_stuff_o, real_mix_o, mix_sign_pos_o});
        chk("fmt", 32'h7, {unsigned_data_o, one_port_o, ext_data_clock_o});
        chk("pll", 32'h7f, {pll_prescaler_o, pll_enable_o, pump_program_o, pump_ctrl_o});
        $display("test masks done");
        for (v = 0; v < 4; v = v + 1) begin
            wr(5'h01, 2'd0, v * 8'h50);
            chk("rate", v * 5, {interp_rate_o, mod_mode_o});
        end
        wr(5'h04, 2'd0, 32'h80);
        @(posedge clk_i) pll_lock_i <= 1'b1;
        rd(5'h00, 2'd0);
        chk("lock", 32'h02, ro);
        wr(5'h04, 2'd0, 32'h00);
        rd(5'h00, 2'd0);
        chk("lockoff", 32'h00, ro);
        $display("test modes done");
        wr(5'h00, 2'd0, 32'hc0);
        lsb = 1'b1;
        rd(5'h01, 2'd1);
        chk("lsb", {16'h0, `MASK_02, 8'hf0}, ro);
        chk("bidir", {16'h0, `MASK_02, 8'hf0}, rs);
        wr(5'h00, 2'd0, 32'hf4);
        rd(5'h00, 2'd3);
        chk("srst", 32'hd4, ro);
        chk("slp", 32'h5, {sleep_o, power_down_o, reference_resistor_mode_o});
        wr(5'h00, 2'd0, 32'h08);
        lsb = 1'b0;
        rd(5'h00, 2'd0);
        chk("pdn", 32'h08, ro);
        chk("pdn_o", 32'h1, {sleep_o, power_down_o});
        $display("test order and reset done");
        results;
    end
    // watchdog: the sequence needs well under a third of this span
    initial begin
        #300000;
        n_fail = n_fail + 1;
        results;
    end
endmodule // tb_dual_dac_mode_control
bind dual_dac_mode_control dual_dac_mode_control_properties chk_u (.clk_i, .rst_b_i, .sclk_i, .cs_b_i,
    .sdio_o, .sdio_oe_o, .sdo_o, .interp_rate_o, .inphase_offset_o, .sleep_o, .pll_prescaler_o);
